// ---- core/rlpc_pkg.sv ----
// Constants, types and register map of the reset and low-power controller
package rlpc_pkg;

  // Clock period of pclk in nanoseconds
  localparam int unsigned CLK_PERIOD_NS = 50;

  // Base system reset sequence and extra crystal start-up time
  localparam int unsigned RST_SEQ_NS = 33000;
  localparam int unsigned XTAL_EXTRA_NS = 160000;
  // Least times, rounded up to whole cycles
  localparam int unsigned RST_SEQ_CYC = (RST_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned XTAL_SEQ_CYC = (RST_SEQ_NS + XTAL_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 13;

  // APB register byte offsets
  localparam logic [7:0] ADDR_CAUSE = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_PWR = 8'h08;
  localparam logic [7:0] ADDR_DBG = 8'h0C;
  localparam logic [7:0] ADDR_PIN = 8'h10;
  localparam logic [7:0] ADDR_STATE = 8'h14;

  // Cause / interrupt status bit positions
  localparam int unsigned CAUSE_POR = 0;
  localparam int unsigned CAUSE_BROWN = 1;
  localparam int unsigned CAUSE_WDT = 2;
  localparam int unsigned CAUSE_PIN = 3;
  localparam int unsigned CAUSE_DBG = 4;
  localparam int unsigned CAUSE_SMR = 5;
  localparam int unsigned CAUSE_W = 6;

  // Pin configuration field positions
  localparam int unsigned PIN_GPIO = 0;
  localparam int unsigned PIN_DATA = 1;
  localparam int unsigned PIN_HIDRV = 2;
  localparam int unsigned PIN_SMRE_LO = 8;
  localparam int unsigned GPIO_W = 8;

  // Debugger control reset request bit
  localparam int unsigned DBG_RST = 0;

  // Reset values
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 6'h00;
  localparam logic [CAUSE_W-1:0] MASK_RST = 6'h00;
  localparam logic [7:0] PWR_RST = 8'h00;
  localparam logic [15:0] PIN_RST = 16'h0000;

  // Sequencer states
  typedef enum logic [1:0] {RLPC_HOLD, RLPC_COUNT, RLPC_RUN} rlpc_state_t;

  // Shared reset pin drive bundle
  typedef struct packed {
    logic out;
    logic oe_n;
    logic pullup_en;
    logic hidrive_en;
  } rlpc_pin_t;

  // APB request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rlpc_apb_req_t;

endpackage : rlpc_pkg

// ---- core/rlpc_top.sv ----
// Reset sequencer, stop/halt control, peripheral power gating, APB registers
`timescale 1ns/1ns
module rlpc_top
  import rlpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire rlpc_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic por_ok,
  input wire logic supply_dropout_detect,
  input wire logic watchdog_timeout,
  input wire logic watchdog_reset_option,
  input wire logic xtal_option,
  input wire logic stop_mode,
  input wire logic halt_req,
  input wire logic irq_pending,
  input wire logic [GPIO_W-1:0] gpio_in,
  input wire logic shared_reset_port_pin_in,
  output rlpc_pin_t shared_reset_port_pin,
  output logic sys_reset_n,
  output logic cpu_halted,
  output logic stop_recovery,
  output logic [7:0] periph_clk_en,
  output logic irq
);

  // Address match helper, used by write decode and the unmapped-address check
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // Known register offset check
  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, ADDR_CAUSE) | hit(a, ADDR_MASK) | hit(a, ADDR_PWR)
           | hit(a, ADDR_DBG) | hit(a, ADDR_PIN) | hit(a, ADDR_STATE);
  endfunction : mapped

  // Analog and pin inputs, three-stage synchronisers
  logic [2:0] por_sync_r;
  logic [2:0] bo_sync_r;
  logic [2:0] pin_sync_r;
  logic por_ok_r;        // Filtered supply-good level
  logic bo_r;            // Filtered brown-out level
  logic pin_lvl_r;       // Filtered shared pin level
  logic pin_armed_r; // Pin seen high since run began; arms the pin reset
  logic [GPIO_W-1:0] gpio_lvl_r;   // Filtered GPIO levels
  logic [GPIO_W-1:0] gpio_prev_r;  // Levels one cycle earlier

  // Control state
  rlpc_state_t state_r;
  rlpc_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;         // Reset sequence counter
  logic por_pend_r;                // Supply loss seen, flag at sequence end
  logic [CAUSE_W-1:0] cause_r;     // Sticky causes, write one to clear
  logic [CAUSE_W-1:0] mask_r;      // Interrupt enables
  logic [7:0] pwr_r;               // Peripheral disable bits
  logic [15:0] pin_cfg_r;          // Shared pin mode and recovery enables
  logic dbg_rst_r;                 // Debugger reset request, self-clearing

  // Bus strobes
  logic wr_en;
  assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;

  // Event terms
  logic supply_low;
  logic pin_reset_mode;
  logic pin_assert;
  logic wdt_rst_evt;
  logic smr_evt;
  logic [CAUSE_W-1:0] cause_set;
  logic [GPIO_W-1:0] smr_en;
  logic seq_len_done;
  logic [CNT_W-1:0] seq_len;

  // Below threshold or dropping out, both hold reset
  assign supply_low = ~por_ok_r | bo_r;
  // Pin stays a reset pin until software selects GPIO
  assign pin_reset_mode = ~pin_cfg_r[PIN_GPIO];
  // Low pin counts only once seen high in run; the synchroniser lags our own release
  assign pin_assert = pin_reset_mode & ~pin_lvl_r & pin_armed_r & (state_r == RLPC_RUN);
  // Watchdog reset outside stop mode only; in stop it recovers instead
  assign wdt_rst_evt = watchdog_timeout & watchdog_reset_option & ~stop_mode;
  // Recovery enables for GPIO inputs; the shared pin is never one of them
  assign smr_en = pin_cfg_r[PIN_SMRE_LO +: GPIO_W];
  assign smr_evt = stop_mode & (state_r == RLPC_RUN)
                 & (watchdog_timeout | (|((gpio_lvl_r ^ gpio_prev_r) & smr_en)));
  // Crystal enabled means a longer sequence
  assign seq_len = xtal_option ? CNT_W'(XTAL_SEQ_CYC - 1) : CNT_W'(RST_SEQ_CYC - 1);
  assign seq_len_done = (cnt_r >= seq_len);

  // Cause bits raised this cycle
  always_comb
  begin
    cause_set = '0;
    cause_set[CAUSE_BROWN] = bo_r & (state_r == RLPC_RUN);
    cause_set[CAUSE_WDT] = wdt_rst_evt;
    cause_set[CAUSE_PIN] = pin_assert;
    cause_set[CAUSE_DBG] = dbg_rst_r;
    cause_set[CAUSE_SMR] = smr_evt;
    cause_set[CAUSE_POR] = por_pend_r & (state_r == RLPC_COUNT) & seq_len_done;
  end

  // Supply detector synchronisers; second and third stage must agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      por_sync_r <= 3'h0;
      bo_sync_r <= 3'h0;
      por_ok_r <= 1'b0;
      bo_r <= 1'b0;
    end
    else
    begin
      por_sync_r <= {por_sync_r[1:0], por_ok};
      bo_sync_r <= {bo_sync_r[1:0], supply_dropout_detect};
      if (por_sync_r[1] == por_sync_r[2])  // Only agreed levels pass; one-cycle glitches drop
        por_ok_r <= por_sync_r[2];
      if (bo_sync_r[1] == bo_sync_r[2])
        bo_r <= bo_sync_r[2];
    end
  end

  // Shared pin input synchroniser; released pin reads high by pull-up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_sync_r <= 3'h7;
      pin_lvl_r <= 1'b1;
      pin_armed_r <= 1'b0;
    end
    else
    begin
      pin_sync_r <= {pin_sync_r[1:0], shared_reset_port_pin_in};
      if (pin_sync_r[1] == pin_sync_r[2])
        pin_lvl_r <= pin_sync_r[2];
      pin_armed_r <= (state_r == RLPC_RUN) & (pin_armed_r | pin_lvl_r);
    end
  end

  // GPIO synchronisers, one per bit
  genvar gi;
  generate
    for (gi = 0; gi < GPIO_W; gi++)
    begin : g_gpio_sync
      logic [2:0] s_r;
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          s_r <= 3'h0;
          gpio_lvl_r[gi] <= 1'b0;
          gpio_prev_r[gi] <= 1'b0;
        end
        else
        begin
          s_r <= {s_r[1:0], gpio_in[gi]};
          if (s_r[1] == s_r[2])
            gpio_lvl_r[gi] <= s_r[2];
          gpio_prev_r[gi] <= gpio_lvl_r[gi];  // Previous level for transition detect
        end
      end
    end
  endgenerate

  // Sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      // Held while supply is low
      RLPC_HOLD:
        if (!supply_low)
          state_nxt = RLPC_COUNT;
      // Timed reset sequence
      RLPC_COUNT:
        if (supply_low)
          state_nxt = RLPC_HOLD;
        else if (seq_len_done)
          state_nxt = RLPC_RUN;
      // Running; any source restarts the sequence
      RLPC_RUN:
        if (supply_low)
          state_nxt = RLPC_HOLD;
        else if (wdt_rst_evt | pin_assert | dbg_rst_r)
          state_nxt = RLPC_COUNT;
      default:
        state_nxt = RLPC_HOLD;
    endcase
  end

  // Sequencer state and counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= RLPC_HOLD;
      cnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_nxt != RLPC_COUNT || state_r != RLPC_COUNT)  // Restart on every entry into the timed phase
        cnt_r <= '0;
      else
        cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // Power-on pending: any hold phase ends in a power-on flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      por_pend_r <= 1'b1;
    else if (state_r == RLPC_HOLD)
      por_pend_r <= 1'b1;
    else if (cause_set[CAUSE_POR])
      por_pend_r <= 1'b0;
  end

  // Plain registered outputs: system reset, recovery pulse, clock enables, interrupt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sys_reset_n <= 1'b0;
      stop_recovery <= 1'b0;
      periph_clk_en <= ~PWR_RST;
      irq <= 1'b0;
    end
    else
    begin
      sys_reset_n <= (state_nxt == RLPC_RUN);
      stop_recovery <= smr_evt;
      periph_clk_en <= ~pwr_r;
      irq <= |(cause_r & mask_r);
    end
  end

  // Halt state; clocks and peripherals are untouched by it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cpu_halted <= 1'b0;
    else if (state_nxt != RLPC_RUN)
      cpu_halted <= 1'b0;
    else if (irq_pending | watchdog_timeout)
      cpu_halted <= 1'b0;
    else if (halt_req)
      cpu_halted <= 1'b1;
  end

  // Shared pin drive; oe_n low means driving, reset drives low with pull-up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      shared_reset_port_pin <= '{out: 1'b0, oe_n: 1'b0, pullup_en: 1'b1, hidrive_en: 1'b0};
    else if (pin_reset_mode)
    begin
      // Open drain: pull low during reset, otherwise release
      shared_reset_port_pin.out <= 1'b0;
      shared_reset_port_pin.oe_n <= (state_nxt == RLPC_RUN);
      shared_reset_port_pin.pullup_en <= 1'b1;
      shared_reset_port_pin.hidrive_en <= 1'b0;
    end
    else
    begin
      // GPIO mode drives both levels, never an input
      shared_reset_port_pin.out <= pin_cfg_r[PIN_DATA];
      shared_reset_port_pin.oe_n <= 1'b0;
      shared_reset_port_pin.pullup_en <= 1'b0;
      shared_reset_port_pin.hidrive_en <= pin_cfg_r[PIN_HIDRV];
    end
  end

  // Sticky causes; a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cause_r <= CAUSE_RST;
    else if (wr_en && hit(apb_req.paddr, ADDR_CAUSE))
      cause_r <= (cause_r & ~apb_req.pwdata[CAUSE_W-1:0]) | cause_set;
    else
      cause_r <= cause_r | cause_set;
  end

  // Software control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_r <= MASK_RST;
      pwr_r <= PWR_RST;
      pin_cfg_r <= PIN_RST;
    end
    else if (state_r == RLPC_HOLD)
    begin
      // Power loss returns the pin to its reset function
      pin_cfg_r <= PIN_RST;
    end
    else if (wr_en)
    begin
      if (hit(apb_req.paddr, ADDR_MASK))
        mask_r <= apb_req.pwdata[CAUSE_W-1:0];
      if (hit(apb_req.paddr, ADDR_PWR))
        pwr_r <= apb_req.pwdata[7:0];
      if (hit(apb_req.paddr, ADDR_PIN))
        pin_cfg_r <= apb_req.pwdata[15:0];
    end
  end

  // Debugger reset bit, high one cycle after each write access that sets it, then clears itself
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dbg_rst_r <= 1'b0;
    else
      dbg_rst_r <= wr_en & hit(apb_req.paddr, ADDR_DBG) & apb_req.pwdata[DBG_RST];
  end

  // Zero-wait APB answer; unmapped addresses error and read zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      // Ready in the access cycle after setup, one cycle only
      pready <= apb_req.psel & ~apb_req.penable;
      pslverr <= apb_req.psel & ~apb_req.penable & ~mapped(apb_req.paddr);
      prdata <= 32'h00000000;
      if (apb_req.psel && !apb_req.penable && !apb_req.pwrite)
      begin
        case (apb_req.paddr)
          ADDR_CAUSE: prdata <= {26'h0000000, cause_r};
          ADDR_MASK: prdata <= {26'h0000000, mask_r};
          ADDR_PWR: prdata <= {24'h000000, pwr_r};
          ADDR_PIN: prdata <= {16'h0000, pin_cfg_r};
          ADDR_STATE: prdata <= {24'h000000, bo_r, ~por_ok_r, stop_mode, cpu_halted, 2'(state_r), sys_reset_n,
                                 pin_lvl_r};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule : rlpc_top

// ---- testbench/rlpc_partner.sv ----
// Model of supply detectors, reset button and shared pad
`timescale 1ns/1ns
module rlpc_partner
  import rlpc_pkg::*;
(
  input wire logic pclk,
  input wire logic supply_up, // Supply above power-on level
  input wire logic supply_sag, // Supply below brown-out level
  input wire logic button_press, // External reset button held
  input wire rlpc_pin_t pin_drv,
  output logic por_ok,
  output logic dropout,
  output logic pad
);
  logic float_r = 1'b0; // Undriven node, changes each cycle so no stale level survives
  // Detectors follow the supply; a sag is also below the power-on level
  always_comb por_ok = supply_up && !supply_sag;
  always_comb dropout = supply_sag;
  // Floating node toggles
  always_ff @(posedge pclk) float_r <= !float_r;
  // Pad: device drive wins, then button, then pull-up
  always_comb
  begin
    if (!pin_drv.oe_n)
      pad = pin_drv.out;
    else if (button_press)
      pad = 1'b0;
    else if (pin_drv.pullup_en)
      pad = 1'b1;
    else
      pad = float_r;
  end
endmodule : rlpc_partner

// ---- testbench/rlpc_sva.sv ----
// Assertion checker for the reset and low-power controller
`timescale 1ns/1ns
module rlpc_sva
  import rlpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire rlpc_apb_req_t apb_req,
  input wire logic pready,
  input wire logic por_ok,
  input wire logic supply_dropout_detect,
  input wire logic watchdog_timeout,
  input wire logic watchdog_reset_option,
  input wire logic stop_mode,
  input wire logic halt_req,
  input wire logic irq_pending,
  input wire logic sys_reset_n,
  input wire logic cpu_halted,
  input wire logic stop_recovery
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // First access cycle of a transfer
  sequence s_access;
    apb_req.psel && apb_req.penable && !$past(apb_req.penable);
  endsequence
  // Halted core sees a wake event
  sequence s_wake;
    cpu_halted && (irq_pending || watchdog_timeout) && !halt_req;
  endsequence
  a_pready_first: assert property (s_access |-> pready) else $error("pready late");
  a_pready_only: assert property (pready |-> apb_req.psel && apb_req.penable) else $error("stray pready");
  a_halt_enter: assert property (halt_req && sys_reset_n && !irq_pending && !watchdog_timeout |=> cpu_halted)
    else $error("halt not entered");
  a_halt_exit: assert property (s_wake |=> !cpu_halted) else $error("halt not left");
  a_brown_hold: assert property (supply_dropout_detect [*8] |-> !sys_reset_n) else $error("no brownout reset");
  a_por_hold: assert property (!por_ok [*8] |-> !sys_reset_n) else $error("no reset below threshold");
  a_wdt_reset: assert property (watchdog_timeout && watchdog_reset_option && !stop_mode && sys_reset_n
    |-> ##[1:3] !sys_reset_n) else $error("watchdog reset missing");
  a_wdt_recover: assert property (watchdog_timeout && stop_mode && sys_reset_n |-> ##[1:2] stop_recovery)
    else $error("stop recovery missing");
  a_recover_cause: assert property (stop_recovery |-> $past(stop_mode)) else $error("recovery outside stop");
  a_reset_min: assert property ($fell(sys_reset_n) |-> !sys_reset_n [*8]) else $error("reset too short");
endmodule : rlpc_sva

bind rlpc_top rlpc_sva u_sva (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .pready(pready),
  .por_ok(por_ok), .supply_dropout_detect(supply_dropout_detect), .watchdog_timeout(watchdog_timeout),
  .watchdog_reset_option(watchdog_reset_option), .stop_mode(stop_mode), .halt_req(halt_req),
  .irq_pending(irq_pending), .sys_reset_n(sys_reset_n), .cpu_halted(cpu_halted), .stop_recovery(stop_recovery));

// ---- testbench/rlpc_top_bench.sv ----
// Self-checking bench for the reset and low-power controller
`timescale 1ns/1ns
module rlpc_top_bench;
  import rlpc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  rlpc_apb_req_t req = '0;
  logic [31:0] prdata, rd, v;
  logic pready, pslverr, por_ok, dropout, pad, srn, halted, smr, irq, err, seen;
  logic wdt = 1'b0, wdt_opt = 1'b0, xtal = 1'b0, stop = 1'b0, halt = 1'b0, irqp = 1'b0;
  logic sup = 1'b0, sag = 1'b0, press = 1'b0;
  logic [7:0] gpio = 8'h00;
  logic [7:0] pce;
  rlpc_pin_t pin;
  integer fails = 0, n_compared = 0, seed = 10, i, low_n = 0, last_low = 0;
  // Clock, 50 ns period
  initial
  begin
    forever #25 pclk = ~pclk;
  end
  // Length in edges of the latest completed low period of the system reset
  always @(posedge pclk)
  begin
    low_n <= (srn === 1'b0) ? low_n + 1 : 0;
    if (srn === 1'b1 && low_n != 0)
      last_low <= low_n;
  end
  rlpc_top uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .por_ok(por_ok), .supply_dropout_detect(dropout), .watchdog_timeout(wdt),
    .watchdog_reset_option(wdt_opt), .xtal_option(xtal), .stop_mode(stop), .halt_req(halt),
    .irq_pending(irqp), .gpio_in(gpio), .shared_reset_port_pin_in(pad), .shared_reset_port_pin(pin),
    .sys_reset_n(srn), .cpu_halted(halted), .stop_recovery(smr), .periph_clk_en(pce), .irq(irq));
  rlpc_partner u_partner (.pclk(pclk), .supply_up(sup), .supply_sag(sag), .button_press(press),
    .pin_drv(pin), .por_ok(por_ok), .dropout(dropout), .pad(pad));
  // Expected clock enables: inverse of disable bits
  function automatic logic [7:0] exp_clk(input logic [7:0] dis);
    return ~dis;
  endfunction : exp_clk
  // Cause bit raised by each reset source
  function automatic logic [31:0] src_cause(input integer k);
    return 32'h1 << ((k == 1) ? CAUSE_WDT : (k == 2) ? CAUSE_PIN : CAUSE_DBG);
  endfunction : src_cause
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Bounded wait ran out
  task automatic hang;
    fails++;
    final_report();
  endtask : hang
  // One APB transfer, request held until pready, then one idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    integer k;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
      hang();
    rd = prdata;
    err = pslverr;
    req <= '0;
    @(posedge pclk);
  endtask : apb
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(n, exp, rd);
  endtask : rdc
  // Wait for one system reset and its end; its length comes from the low-period monitor
  task automatic rst_len(input integer min);
    integer k;
    k = 0;
    while (srn !== 1'b0 && k < 40)
    begin
      @(posedge pclk);
      k++;
    end
    if (k >= 40)
      hang();
    press <= 1'b0;
    #1 chk("pin_drive_low", 32'h0, {pin.out, pin.oe_n});
    k = 0;
    while (srn !== 1'b1 && k < 6000)
    begin
      @(posedge pclk);
      k++;
    end
    if (k >= 6000)
      hang();
    #1 chk("reset_len_ok", 32'h1, last_low >= min);
  endtask : rst_len
  // Watch for a recovery pulse over ten cycles
  task automatic wait_smr;
    seen = 1'b0;
    repeat (10)
    begin
      @(posedge pclk);
      seen = seen | smr;
    end
  endtask : wait_smr
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // Main sequence
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    sup <= 1'b1;
    rst_len(RST_SEQ_CYC);
    #1 chk("pin_mode", 32'h1, {pin.oe_n, pin.pullup_en} == 2'b11);
    rdc("cause_por", ADDR_CAUSE, 32'h1 << CAUSE_POR);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped_err", 32'h1, err);
    rdc("dbg_read", ADDR_DBG, 32'h0);
    // Interrupt unmasked, masked, cleared
    apb(1'b1, ADDR_MASK, 32'h1 << CAUSE_POR);
    repeat (2) @(posedge pclk);
    chk("irq_on", 32'h1, irq);
    apb(1'b1, ADDR_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq_masked", 32'h0, irq);
    apb(1'b1, ADDR_MASK, 32'h3F);
    apb(1'b1, ADDR_CAUSE, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_cleared", 32'h0, irq);
    // Peripheral disables, corners then random
    for (i = 0; i < 6; i++)
    begin
      v = (i < 2) ? {32{i[0]}} : $random(seed);
      apb(1'b1, ADDR_PWR, v);
      repeat (2) @(posedge pclk);
      #1 chk("clk_en", exp_clk(v[7:0]), pce);
    end
    // Halt, woken by interrupt then watchdog
    for (i = 0; i < 2; i++)
    begin
      halt <= 1'b1;
      @(posedge pclk);
      halt <= 1'b0;
      repeat (3) @(posedge pclk);
      #1 chk("halted", 32'h1, {halted, srn, pce} == {2'b11, exp_clk(v[7:0])});
      irqp <= (i == 0);
      wdt <= (i == 1);
      @(posedge pclk);
      irqp <= 1'b0;
      wdt <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("halt_left", 32'h0, halted);
    end
    // Stop recovery: enabled pin, disabled pins, watchdog
    stop <= 1'b1;
    apb(1'b1, ADDR_PIN, 32'h100);
    gpio[0] <= 1'b1;
    wait_smr();
    chk("smr_pin", 32'h1, seen);
    gpio[7:1] <= 7'($random(seed));
    wait_smr();
    chk("smr_off_pin", 32'h0, seen);
    wdt_opt <= 1'b1;
    wdt <= 1'b1;
    @(posedge pclk);
    wdt <= 1'b0;
    wait_smr();
    chk("smr_wdt", 32'h1, {seen, srn} == 2'b11);
    stop <= 1'b0;
    rdc("cause_smr", ADDR_CAUSE, 32'h1 << CAUSE_SMR);
    apb(1'b1, ADDR_CAUSE, 32'h3F);
    // Debugger, watchdog, pin, debugger with crystal
    for (i = 0; i < 4; i++)
    begin
      xtal <= (i == 3);
      @(posedge pclk);
      if (i == 1)
        wdt <= 1'b1;
      else if (i == 2)
        press <= 1'b1;
      else
        apb(1'b1, ADDR_DBG, 32'h1);
      @(posedge pclk);
      wdt <= 1'b0;
      rst_len((i == 3) ? XTAL_SEQ_CYC : RST_SEQ_CYC);
      rdc("cause_src", ADDR_CAUSE, src_cause(i));
      apb(1'b1, ADDR_CAUSE, 32'h3F);
    end
    xtal <= 1'b0;
    // Pin as output, then brownout restores reset mode
    apb(1'b1, ADDR_PIN, 32'h7);
    repeat (2) @(posedge pclk);
    #1 chk("gpio_drive", 32'h5, {pin.out, pin.oe_n, pin.hidrive_en});
    sag <= 1'b1;
    repeat (20) @(posedge pclk);
    chk("brown_hold", 32'h0, srn);
    sag <= 1'b0;
    rst_len(RST_SEQ_CYC);
    #1 chk("pin_back", 32'h1, pin.oe_n);
    rdc("cause_brown", ADDR_CAUSE, (32'h1 << CAUSE_POR) | (32'h1 << CAUSE_BROWN));
    final_report();
  end
endmodule : rlpc_top_bench
